// *** hdl/ahc_cfg.svh ***
// Offsets, fields, reset values and timing counts of the converter host.
`ifndef AHC_CFG_SVH
`define AHC_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define AHC_OFF_CTRL  8'h00
`define AHC_OFF_CHAN  8'h04
`define AHC_OFF_CMD   8'h08
`define AHC_OFF_STAT  8'h0C
`define AHC_OFF_DATA  8'h10

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define AHC_CTRL_MODE   0
`define AHC_CTRL_SLEEP  1
`define AHC_CTRL_EARLY  2
`define AHC_CTRL_PIPE   3
`define AHC_CTRL_W      4
`define AHC_CTRL_RST    4'h2
`define AHC_CHAN_RST    3'h0
`define AHC_CMD_START   0
`define AHC_STAT_DONE   1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AHC_CLK_NS      4
`define AHC_T_ACQ_NS    160
`define AHC_T_WAKE_NS   360
`define AHC_T_WR_NS     250
`define AHC_T_RD_NS     250
`define AHC_T_ACC0_NS   50
`define AHC_T_ACC1_NS   185
`define AHC_T_ACC2_NS   90
`define AHC_CYC(t)      (((t) + `AHC_CLK_NS - 1) / `AHC_CLK_NS)
`define AHC_N_ACQ       `AHC_CYC(`AHC_T_ACQ_NS)
`define AHC_N_WAKE      `AHC_CYC(`AHC_T_WAKE_NS)
`define AHC_N_WR        `AHC_CYC(`AHC_T_WR_NS)
`define AHC_N_RD        `AHC_CYC(`AHC_T_RD_NS)
`define AHC_N_ACC0      `AHC_CYC(`AHC_T_ACC0_NS)
`define AHC_N_ACC1      `AHC_CYC(`AHC_T_ACC1_NS)
`define AHC_N_ACC2      `AHC_CYC(`AHC_T_ACC2_NS)
`define AHC_N_SYNC      2
`define AHC_CNT_W       8

`endif

// *** hdl/ahc_host.sv ***
// APB-controlled host sequencer for a strobe-driven 8-bit converter.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ahc_cfg.svh"
module ahc_host import ahc_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             chip_select_n,
	output logic             read_strobe_n,
	output logic             wr_pin_o,
	output logic             wr_pin_oe_n,
	input  wire logic        wr_pin_i,
	input  wire logic        done_flag_n,
	input  wire logic [7:0]  adc_data_i,
	output logic             mode_sel,
	output logic             sleep_n,
	output logic [2:0]       chan_sel
);
	localparam int CW = `AHC_CNT_W;

	ahc_pin_if pins ();

	ahc_sync u_sync (
		.pclk        (pclk),
		.presetn     (presetn),
		.done_flag_n (done_flag_n),
		.wr_pin_i    (wr_pin_i),
		.adc_data_i  (adc_data_i),
		.pins        (pins)
	);

	logic [3:0]    ctrl_ff, nxt_ctrl;
	logic [2:0]    chan_ff, nxt_chan;
	logic          start_ff, nxt_start;
	logic          done_ff, nxt_done;
	logic          pready_ff, nxt_pready;
	logic          pslverr_ff, nxt_pslverr;
	logic [31:0]   prdata_ff, nxt_prdata;
	ahc_state_t    state_ff, nxt_state;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic [CW-1:0] acq_ff, nxt_acq;
	logic [CW-1:0] wake_ff, nxt_wake;
	logic          cs_n_ff, nxt_cs_n;
	logic          rd_n_ff, nxt_rd_n;
	logic          wr_o_ff, nxt_wr_o;
	logic          wr_oe_n_ff, nxt_wr_oe_n;
	logic [7:0]    data_ff, nxt_data;
	logic          first_ff, nxt_first;
	logic          sleep_q_ff, nxt_sleep_q;
	logic          evt_ff, nxt_evt;
	logic          mode, early, pipe, awake, idle, ready_ok, go;
	logic          setup, wr_acc, ctrl_wr, chan_wr, early_path;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	assign mode       = ctrl_ff[`AHC_CTRL_MODE];
	assign early      = ctrl_ff[`AHC_CTRL_EARLY];
	assign pipe       = ctrl_ff[`AHC_CTRL_PIPE];
	assign awake      = ctrl_ff[`AHC_CTRL_SLEEP];
	assign idle       = (state_ff == AHC_S_IDLE);
	assign ready_ok   = awake && (acq_ff == '0) && (wake_ff == '0);
	assign go         = idle && start_ff && ready_ok;
	assign setup      = psel && !penable;
	assign wr_acc     = psel && penable && pready_ff && pwrite;
	assign early_path = mode && early && !pipe;
	// Mode and channel stay frozen while a conversion is pending or running.
	assign ctrl_wr = wr_acc && hit(paddr, `AHC_OFF_CTRL) && idle && !start_ff;
	assign chan_wr = wr_acc && hit(paddr, `AHC_OFF_CHAN) && idle && !start_ff;

	// ------------------------------------------------------------------
	// APB register slave
	// ------------------------------------------------------------------
	always_comb begin
		nxt_pready  = setup;
		nxt_prdata  = prdata_ff;
		nxt_pslverr = pslverr_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_chan    = chan_ff;
		nxt_start   = start_ff;
		nxt_done    = done_ff;
		if (setup) begin
			nxt_pslverr = 1'b0;
			case (paddr)
				`AHC_OFF_CTRL: nxt_prdata = {28'h0, ctrl_ff};
				`AHC_OFF_CHAN: nxt_prdata = {29'h0, chan_ff};
				`AHC_OFF_CMD:  nxt_prdata = {31'h0, start_ff};
				`AHC_OFF_STAT: nxt_prdata = {27'h0, pins.wait_lvl, !first_ff,
					ready_ok, done_ff, !idle};
				`AHC_OFF_DATA: nxt_prdata = {24'h0, data_ff};
				default: begin
					nxt_prdata  = 32'h0;
					nxt_pslverr = 1'b1;
				end
			endcase
		end
		if (ctrl_wr)
			nxt_ctrl = pwdata[`AHC_CTRL_W-1:0];
		if (chan_wr)
			nxt_chan = pwdata[2:0];
		if (go)
			nxt_start = 1'b0;
		if (wr_acc && hit(paddr, `AHC_OFF_CMD) && pwdata[`AHC_CMD_START])
			nxt_start = 1'b1;
		if (wr_acc && hit(paddr, `AHC_OFF_STAT) && pwdata[`AHC_STAT_DONE])
			nxt_done = 1'b0;
		if (evt_ff)
			nxt_done = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0;
			pslverr_ff <= 1'b0;
			ctrl_ff    <= `AHC_CTRL_RST;
			chan_ff    <= `AHC_CHAN_RST;
			start_ff   <= 1'b0;
			done_ff    <= 1'b0;
		end else begin
			pready_ff  <= nxt_pready;
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
			ctrl_ff    <= nxt_ctrl;
			chan_ff    <= nxt_chan;
			start_ff   <= nxt_start;
			done_ff    <= nxt_done;
		end
	end

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_cs_n    = cs_n_ff;
		nxt_rd_n    = rd_n_ff;
		nxt_wr_o    = wr_o_ff;
		nxt_wr_oe_n = wr_oe_n_ff;
		nxt_data    = data_ff;
		nxt_first   = first_ff;
		nxt_evt     = 1'b0;
		nxt_sleep_q = awake;
		nxt_acq     = (acq_ff != '0) ? acq_ff - 1'b1 : acq_ff;
		nxt_wake    = (wake_ff != '0) ? wake_ff - 1'b1 : wake_ff;
		if (awake && !sleep_q_ff)
			nxt_wake = CW'(`AHC_N_WAKE);
		if (chan_wr)
			nxt_acq = CW'(`AHC_N_ACQ);
		case (state_ff)
			AHC_S_IDLE: begin
				if (go) begin
					nxt_cs_n = 1'b0;
					if (!mode) begin
						nxt_rd_n  = 1'b0;
						nxt_state = AHC_S_WAITD;
					end else begin
						nxt_wr_o    = 1'b0;
						nxt_wr_oe_n = 1'b0;
						nxt_rd_n    = !pipe;
						nxt_cnt     = CW'(`AHC_N_WR);
						nxt_state   = AHC_S_CONV;
					end
				end
			end
			AHC_S_CONV: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_state = AHC_S_WAITD;
					if (!pipe) begin
						nxt_wr_o = 1'b1;
						nxt_cnt  = early ? CW'(`AHC_N_RD) : '0;
					end
				end
			end
			AHC_S_WAITD: begin
				// read after done unless reading early
				if (early_path ? (cnt_ff == '0) : !pins.done_n) begin
					nxt_rd_n  = 1'b0;
					nxt_state = AHC_S_READ;
					if (!mode)
						nxt_cnt = CW'(`AHC_N_ACC0 + `AHC_N_SYNC);
					else if (early_path)
						nxt_cnt = CW'(`AHC_N_ACC1 + `AHC_N_SYNC);
					else
						nxt_cnt = CW'(`AHC_N_ACC2 + `AHC_N_SYNC);
				end else if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			AHC_S_READ: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					// first result after reset is dropped
					if (!first_ff) begin
						nxt_data = pins.data;
						nxt_evt  = 1'b1;
					end
					nxt_first   = 1'b0;
					nxt_rd_n    = 1'b1;
					nxt_wr_o    = 1'b1;
					nxt_wr_oe_n = 1'b1;
					nxt_acq     = CW'(`AHC_N_ACQ);
					nxt_state   = AHC_S_END;
				end
			end
			AHC_S_END: begin
				nxt_cs_n  = 1'b1;
				nxt_state = AHC_S_IDLE;
			end
			default: nxt_state = AHC_S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff   <= AHC_S_IDLE;
			cnt_ff     <= '0;
			acq_ff     <= '0;
			wake_ff    <= CW'(`AHC_N_WAKE);
			cs_n_ff    <= 1'b1;
			rd_n_ff    <= 1'b1;
			wr_o_ff    <= 1'b1;
			wr_oe_n_ff <= 1'b1;
			data_ff    <= 8'h00;
			first_ff   <= 1'b1;
			sleep_q_ff <= 1'b1;
			evt_ff     <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			acq_ff     <= nxt_acq;
			wake_ff    <= nxt_wake;
			cs_n_ff    <= nxt_cs_n;
			rd_n_ff    <= nxt_rd_n;
			wr_o_ff    <= nxt_wr_o;
			wr_oe_n_ff <= nxt_wr_oe_n;
			data_ff    <= nxt_data;
			first_ff   <= nxt_first;
			sleep_q_ff <= nxt_sleep_q;
			evt_ff     <= nxt_evt;
		end
	end

	assign prdata        = prdata_ff;
	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;
	assign chip_select_n = cs_n_ff;
	assign read_strobe_n = rd_n_ff;
	assign wr_pin_o      = wr_o_ff;
	assign wr_pin_oe_n   = wr_oe_n_ff;
	// mode pin always driven from the control register
	assign mode_sel      = ctrl_ff[`AHC_CTRL_MODE];
	assign sleep_n       = ctrl_ff[`AHC_CTRL_SLEEP];
	assign chan_sel      = chan_ff;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	localparam int N_WAKE_I = `AHC_N_WAKE;
	localparam int N_ACQ_I  = `AHC_N_ACQ;

	property p_rd_needs_cs;
		!rd_n_ff |-> !cs_n_ff;
	endproperty
	a_rd_needs_cs: assert property (p_rd_needs_cs)
		else $error("read strobe low without chip select");

	property p_shared_pin_input;
		(!mode && !$past(mode)) |-> wr_oe_n_ff;
	endproperty
	a_shared_pin_input: assert property (p_shared_pin_input)
		else $error("shared pin driven in read mode");

	property p_wake_load;
		(awake && !sleep_q_ff) |=> wake_ff == CW'(N_WAKE_I);
	endproperty
	a_wake_load: assert property (p_wake_load)
		else $error("wake wait not loaded after sleep release");

	property p_start_after_wake;
		$fell(cs_n_ff) |-> $past(wake_ff) == '0 && $past(awake);
	endproperty
	a_start_after_wake: assert property (p_start_after_wake)
		else $error("conversion started before wake time");

	property p_start_after_acq;
		$fell(cs_n_ff) |-> $past(acq_ff) == '0;
	endproperty
	a_start_after_acq: assert property (p_start_after_acq)
		else $error("conversion started within acquisition time");

	property p_chan_settle;
		chan_wr |=> acq_ff == CW'(N_ACQ_I) && idle;
	endproperty
	a_chan_settle: assert property (p_chan_settle)
		else $error("address change did not restart settle time");

	property p_read_mode_start;
		($fell(cs_n_ff) && !mode) |-> $fell(rd_n_ff) && wr_oe_n_ff;
	endproperty
	a_read_mode_start: assert property (p_read_mode_start)
		else $error("read mode start without read strobe");

	property p_single_read;
		$rose(rd_n_ff) |-> $past(state_ff) == AHC_S_READ ##1 $rose(cs_n_ff);
	endproperty
	a_single_read: assert property (p_single_read)
		else $error("read strobe released before capture");

	property p_read_after_done;
		($fell(rd_n_ff) && mode && !early && !pipe) |-> !$past(pins.done_n);
	endproperty
	a_read_after_done: assert property (p_read_after_done)
		else $error("read before done in internal delay mode");

	property p_first_dropped;
		$fell(first_ff) |-> $stable(data_ff) && !done_ff;
	endproperty
	a_first_dropped: assert property (p_first_dropped)
		else $error("first conversion result was kept");

	c_read_mode: cover property ($rose(evt_ff) && !mode);
	c_early_read: cover property ($rose(evt_ff) && early_path);
	c_pipelined: cover property ($rose(evt_ff) && mode && pipe);
	c_wake: cover property ($fell(wake_ff == '0) && awake ##[1:200] go);
endmodule

// *** hdl/ahc_pin_if.sv ***
// Synchronised converter pin levels passed to the host sequencer.
`timescale 1ns/1ps
interface ahc_pin_if;
	logic       done_n;
	logic       wait_lvl;
	logic [7:0] data;

	modport syncd (output done_n, output wait_lvl, output data);
	modport ctrl  (input done_n, input wait_lvl, input data);
endinterface

// *** hdl/ahc_pkg.sv ***
// Types shared by the converter host modules.
package ahc_pkg;

	typedef enum logic [2:0] {
		AHC_S_IDLE  = 3'h0,
		AHC_S_CONV  = 3'h1,
		AHC_S_WAITD = 3'h3,
		AHC_S_READ  = 3'h2,
		AHC_S_END   = 3'h6
	} ahc_state_t;

endpackage

// *** hdl/ahc_sync.sv ***
// Two-stage synchronisers for every converter pin read by the host.
`timescale 1ns/1ps
module ahc_sync (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       done_flag_n,
	input  wire logic       wr_pin_i,
	input  wire logic [7:0] adc_data_i,
	ahc_pin_if.syncd        pins
);
	localparam int        W   = 10;
	localparam logic [9:0] RST = 10'h300;

	logic [W-1:0] raw;
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;

	assign raw = {wr_pin_i, done_flag_n, adc_data_i};

	// ------------------------------------------------------------------
	// Per-bit synchronisers
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_ff[i] <= RST[i];
					s2_ff[i] <= RST[i];
				end else begin
					s1_ff[i] <= raw[i];
					s2_ff[i] <= s1_ff[i];
				end
			end
		end
	endgenerate

	assign pins.data     = s2_ff[7:0];
	assign pins.done_n   = s2_ff[8];
	assign pins.wait_lvl = s2_ff[9];
endmodule

// *** verif/ahc_adc_model.sv ***
// Behavioural model of the strobe-driven 8-bit converter.
`timescale 1ns/1ps
module ahc_adc_model #(
	parameter int T_RDC  = 600,
	parameter int SELF_TIMED_DELAY = 900,
	parameter int T_ACC1 = 185
) (
	input  wire logic       chip_select_n,
	input  wire logic       read_strobe_n,
	input  wire logic       wr_lvl,
	input  wire logic       mode_sel,
	input  wire logic       sleep_n,
	input  wire logic [2:0] chan_sel,
	output logic            done_flag_n,
	output logic            rdy_pull,
	output logic [7:0]      data
);
	logic [7:0] out_q, last_q, res;
	logic       busy, pipe, pcs, prd, pwr;
	int         t;

	function automatic logic [7:0] conv(input logic [2:0] c);
		return (c == 3'h7) ? 8'hFF : {1'h0, c, ~c, 1'h1};
	endfunction

	task automatic start(input logic p, input int n);
		busy = 1'h1;
		pipe = p;
		t = n;
		res = conv(chan_sel);
		if (p)
			out_q = last_q;
	endtask

	initial begin
		{busy, pipe, rdy_pull, out_q, last_q, res} = '0;
		{done_flag_n, pcs, prd, pwr} = 4'hF;
		t = 0;
		forever begin
			#1;
			if ((chip_select_n && !pcs) || (read_strobe_n && !prd))
				done_flag_n = 1'h1;
			if (!sleep_n) begin
				busy = 1'h0;
				rdy_pull = 1'h0;
			end
			if (!chip_select_n && sleep_n) begin
				if (mode_sel !== 1'h1) begin
					if (pcs)
						rdy_pull = 1'h1;
					if (!read_strobe_n && (prd || pcs) && !busy)
						start(1'h0, T_RDC);
				end else begin
					if (!wr_lvl && pwr)
						start(!read_strobe_n, SELF_TIMED_DELAY);
					if (wr_lvl && !pwr && !pipe)
						out_q[7:4] = res[7:4];
					if (!read_strobe_n && prd && busy && wr_lvl && t > T_ACC1)
						t = T_ACC1;
				end
			end
			if (busy && t > 0)
				t = t - 1;
			if (busy && t == 0) begin
				busy = 1'h0;
				rdy_pull = 1'h0;
				done_flag_n = 1'h0;
				if (!pipe)
					out_q = res;
				last_q = res;
			end
			{pcs, prd, pwr} = {chip_select_n, read_strobe_n, wr_lvl};
		end
	end

	always_comb begin
		if (!chip_select_n && !read_strobe_n)
			data = out_q;
		else
			data = ~out_q;
	end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the converter host and its device model.
`timescale 1ns/1ps
`include "ahc_cfg.svh"
module tb;
	typedef struct {
		logic [3:0] ctrl;
		logic [2:0] chan;
		logic [7:0] code;
	} ahc_row_t;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, adc_data;
	logic [31:0] pwdata, prdata, rd;
	logic        chip_select_n, read_strobe_n, wr_pin_o, wr_pin_oe_n;
	logic        wr_lvl, done_flag_n, rdy_pull, mode_sel, sleep_n;
	logic [2:0]  chan_sel;
	int          errors, check_count, n;
	ahc_row_t    rows [7];

	// Open-drain shared pin with pull-up.
	assign wr_lvl = (wr_pin_oe_n == 1'h0) ? wr_pin_o : ~rdy_pull;

	ahc_host ahc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chip_select_n(chip_select_n),
		.read_strobe_n(read_strobe_n), .wr_pin_o(wr_pin_o),
		.wr_pin_oe_n(wr_pin_oe_n), .wr_pin_i(wr_lvl),
		.done_flag_n(done_flag_n), .adc_data_i(adc_data),
		.mode_sel(mode_sel), .sleep_n(sleep_n), .chan_sel(chan_sel));

	ahc_adc_model ahc_adc_model_i (.chip_select_n(chip_select_n),
		.read_strobe_n(read_strobe_n), .wr_lvl(wr_lvl),
		.mode_sel(mode_sel), .sleep_n(sleep_n), .chan_sel(chan_sel),
		.done_flag_n(done_flag_n), .rdy_pull(rdy_pull), .data(adc_data));

	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t pin got %h exp %h", $time, got, exp);
		end
	endtask

	// Called just after a rising edge; returns one idle edge after release.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic go(input logic [3:0] c, input logic [2:0] ch);
		apb(1'h1, `AHC_OFF_CTRL, {28'h0, c});
		apb(1'h1, `AHC_OFF_CHAN, {29'h0, ch});
		apb(1'h1, `AHC_OFF_CMD, 32'h1);
	endtask

	task automatic wait_stat(input int b);
		int k;
		k = 0;
		do begin
			apb(1'h0, `AHC_OFF_STAT, 32'h0);
			k++;
		end while (rd[b] !== 1'h1 && k < 400);
		chk_pin(rd[b], 1'h1);
	endtask

	// Catch a hang well beyond the expected run length.
	initial begin
		repeat (30000) @(posedge pclk);
		errors++;
		$display("watchdog expired");
		close_out();
	end

	// Pin relations watched on every cycle.
	always @(negedge pclk) begin
		if (presetn === 1'h1 && read_strobe_n === 1'h0)
			chk_pin(chip_select_n, 1'h0);
		if (presetn === 1'h1 && mode_sel === 1'h0)
			chk_pin(wr_pin_oe_n, 1'h1);
	end

	initial begin
		rows = '{'{4'h2, 3'h7, 8'hFF}, '{4'h2, 3'h2, 8'h2B},
			'{4'h3, 3'h5, 8'h55}, '{4'h7, 3'h1, 8'h1D},
			'{4'hB, 3'h3, 8'h1D}, '{4'hB, 3'h6, 8'h39},
			'{4'h3, 3'h0, 8'h0F}};
		{psel, penable, pwrite, paddr, pwdata} = '0;
		errors = 0;
		check_count = 0;
		presetn = 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(negedge pclk);
		chk_pin(chip_select_n, 1'h1);
		chk_pin(read_strobe_n, 1'h1);
		chk_pin(wr_pin_o, 1'h1);
		chk_pin(mode_sel, 1'h0);
		chk_pin(sleep_n, 1'h1);
		@(posedge pclk);
		apb(1'h0, `AHC_OFF_CTRL, 32'h0);
		chk_word(rd, {28'h0, `AHC_CTRL_RST});
		apb(1'h0, `AHC_OFF_CHAN, 32'h0);
		chk_word(rd, 32'h0);
		apb(1'h0, 8'h14, 32'h0);
		chk_word(rd, 32'h0);
		chk_pin(err, 1'h1);
		$display("test reset done");
		// First conversion only primes the converter.
		go(4'h2, 3'h4);
		wait_stat(3);
		chk_pin(rd[1], 1'h0);
		chk_pin(rd[4], 1'h1);
		$display("test prime done");
		foreach (rows[i]) begin
			go(rows[i].ctrl, rows[i].chan);
			chk_pin(mode_sel, rows[i].ctrl[0]);
			chk_word({29'h0, chan_sel}, {29'h0, rows[i].chan});
			wait_stat(`AHC_STAT_DONE);
			apb(1'h0, `AHC_OFF_DATA, 32'h0);
			chk_word(rd, {24'h0, rows[i].code});
			apb(1'h1, `AHC_OFF_STAT, 32'h2);
			$display("test row %0d done", i);
		end
		// Sleep, then wake and start: conversion waits the wake time.
		apb(1'h1, `AHC_OFF_CTRL, 32'h0);
		@(negedge pclk);
		chk_pin(sleep_n, 1'h0);
		@(posedge pclk);
		apb(1'h1, `AHC_OFF_CTRL, 32'h2);
		apb(1'h1, `AHC_OFF_CMD, 32'h1);
		// Edges since sleep_n rose: one after the control write, three more.
		n = 4;
		while (chip_select_n !== 1'h0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk_pin(n > `AHC_N_WAKE && n < 400, 1'h1);
		wait_stat(`AHC_STAT_DONE);
		apb(1'h0, `AHC_OFF_DATA, 32'h0);
		chk_word(rd, 32'h0F);
		$display("test wake done");
		// A reset in mid conversion must put the pins back at rest.
		apb(1'h1, `AHC_OFF_STAT, 32'h2);
		apb(1'h1, `AHC_OFF_CMD, 32'h1);
		repeat (100) @(posedge pclk);
		chk_pin(chip_select_n, 1'h0);
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(negedge pclk);
		chk_pin(chip_select_n, 1'h1);
		chk_pin(read_strobe_n, 1'h1);
		@(posedge pclk);
		apb(1'h0, `AHC_OFF_STAT, 32'h0);
		chk_word({28'h0, rd[3:0]}, 32'h0);
		$display("test mid reset done");
		close_out();
	end
endmodule
